// >>> bench/fcc_asserts.sv
`timescale 1ns/100ps
module fcc_asserts (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // modes and outputs
  input wire logic        stop_mode,
  input wire logic        hv_enable
);
  // read request taken in an address phase
  logic rd_go;
  assign rd_go = hsel & htrans[1] & hready & !hwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_zero_wait: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  a_busy_read: assert property (rd_go && haddr[20] && hv_enable |=> hrdata == 32'h0)
    else $error("array read while busy not invalid");
  a_gap_read: assert property (rd_go && !haddr[20] && haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_word_width: assert property (rd_go |=> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_read_hold: assert property (!rd_go |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_stop_hv: assert property (stop_mode [*2] |-> !hv_enable)
    else $error("high voltage on in stop");
  a_hv_start: assert property ($fell(stop_mode) |-> !hv_enable)
    else $error("operation survived stop");
endmodule : fcc_asserts

bind fcc_top fcc_asserts u_asserts (.*);

// >>> bench/fcc_master.sv
`timescale 1ns/100ps
module fcc_master (
  // clock and slave answer
  input  wire logic        core_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end
  // single transfer: address held until hready, then data phase
  task xfer(input logic w, input logic [31:0] a, d, input logic [2:0] sz,
            output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= sz;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d; // released data shows no stale value
  endtask : xfer
endmodule : fcc_master

// >>> bench/flash_command_controller_test.sv
`timescale 1ns/100ps
module flash_command_controller_test;
  import fcc_pkg::*;
  // clock, reset, bus and mode signals
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        hsel, hwrite, hready, hreadyout, hresp, flash_irq, hv_enable;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        wait_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        background_debug_mode = 1'b0;
  logic        secure_en = 1'b0;
  logic        nonsecure_src = 1'b0;
  int          n_fail   = 0;
  int          compares = 0;
  // single slave: its ready is the bus ready
  assign hready = hreadyout;
  always #12.5 core_clk = ~core_clk;
  fcc_top DUT (.*);
  fcc_master u_cpu (.*);
  // bus helpers and comparison
  task wr(input logic [31:0] a, d);
    u_cpu.xfer(1'b1, a, d, SIZE_WORD, rv);
  endtask : wr
  task rd(input logic [31:0] a);
    u_cpu.xfer(1'b0, a, 32'h0, SIZE_WORD, rv);
  endtask : rd
  task chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic [7:0] o, input logic [31:0] d);
    wr({24'h0, o}, d);
  endtask : wreg
  task rreg(input logic [7:0] o, input logic [31:0] m, e);
    rd({24'h0, o});
    chk(rv & m, e);
  endtask : rreg
  function automatic logic [31:0] aw(input logic [14:0] i);
    return 32'h0010_0000 | {15'h0, i, 2'b00};
  endfunction : aw
  task rarr(input logic [14:0] i, input logic [31:0] e);
    rd(aw(i));
    chk(rv, e);
  endtask : rarr
  // word, command, launch
  task seq(input logic [14:0] i, input logic [15:0] d, input logic [7:0] c);
    wr(aw(i), {16'h0, d});
    wreg(OFS_CMD, {24'h0, c});
    wreg(OFS_STAT, 32'h80);
  endtask : seq
  // poll one status bit under a bounded count
  task wait_bit(input int b);
    for (int k = 0; k < 30000; k++) begin
      rd({24'h0, OFS_STAT});
      if (rv[b] === 1'b1) break;
    end
    chk(rv[b], 1'b1);
  endtask : wait_bit
  // scenarios
  task t_base;
    rreg(OFS_STAT, 32'hff, 32'hc0);
    rreg(OFS_DIV, 32'hff, 32'h00);
    rreg(8'h14, 32'hffffffff, 32'h0);
    wr(aw(15'h1), 32'h0);
    rreg(OFS_STAT, 32'h10, 32'h10);
    wreg(OFS_STAT, 32'h0);
    rreg(OFS_STAT, 32'h10, 32'h10);
    wreg(OFS_STAT, 32'h10);
    rreg(OFS_STAT, 32'h10, 32'h0);
    wreg(OFS_DIV, 32'h0);
    rreg(OFS_DIV, 32'hff, 32'h80);
    wreg(OFS_CFG, 32'h80);
    rreg(OFS_CFG, 32'hc0, 32'h80);
    chk({31'h0, flash_irq}, 32'h1);
    wreg(OFS_CFG, 32'h0);
    $display("test base done");
  endtask : t_base
  task t_ops;
    seq(15'h1234, 16'h5a5a, CMD_MASS);
    rreg(OFS_STAT, 32'h40, 32'h0);
    chk({31'h0, hv_enable}, 32'h1);
    rarr(15'h0, 32'h0);
    wait_bit(STAT_CC);
    seq(15'h7, 16'h1, CMD_VERIFY);
    wait_bit(STAT_CC);
    rreg(OFS_STAT, 32'hff, 32'hc4);
    wait_mode <= 1'b1;
    seq(15'h10, 16'h1234, CMD_PROGRAM);
    wait_bit(STAT_CBE);
    seq(15'h11, 16'h00c3, CMD_PROGRAM);
    rreg(OFS_STAT, 32'hc0, 32'h0);
    wait_bit(STAT_CC);
    wait_mode <= 1'b0;
    rarr(15'h10, 32'h1234);
    rarr(15'h11, 32'h00c3);
    seq(15'h0, 16'h0, CMD_VERIFY);
    wait_bit(STAT_CC);
    rreg(OFS_STAT, 32'h04, 32'h0);
    seq(15'h210, 16'h00ff, CMD_PROGRAM);
    wait_bit(STAT_CC);
    seq(15'h3ff, 16'hdead, CMD_SECTOR);
    wait_bit(STAT_CC);
    rarr(15'h210, 32'hffff);
    rarr(15'h10, 32'h1234);
    $display("test ops done");
  endtask : t_ops
  task t_stop;
    seq(15'h200, 16'h0, CMD_SECTOR);
    stop_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    rreg(OFS_STAT, 32'h50, 32'h50);
    stop_mode <= 1'b0;
    @(posedge core_clk);
    rreg(OFS_STAT, 32'h80, 32'h80);
    chk({31'h0, hv_enable}, 32'h0);
    wreg(OFS_STAT, 32'h10);
    $display("test stop done");
  endtask : t_stop
  task t_errs;
    for (int n = 0; n < 6; n++) begin
      if (n > 0 && n < 5) wr(aw(15'h20), 32'h0);
      case (n)
        0: u_cpu.xfer(1'b1, aw(15'h20), 32'h0, 3'h0, rv);
        1: wr(aw(15'h21), 32'h0);
        2: wreg(OFS_CFG, 32'h0);
        3: wreg(OFS_CMD, 32'h33);
        4: begin
          wreg(OFS_CMD, 32'(CMD_PROGRAM));
          wreg(OFS_STAT, 32'h0);
        end
        default: wreg(OFS_CMD, 32'(CMD_PROGRAM));
      endcase
      rreg(OFS_STAT, 32'h50, 32'h50);
      wreg(OFS_STAT, 32'h10);
    end
    $display("test errors done");
  endtask : t_errs
  task t_prot;
    wreg(OFS_PROT, 32'h6);
    seq(15'h30, 16'h0, CMD_PROGRAM);
    rreg(OFS_STAT, 32'h60, 32'h60);
    seq(15'h500, 16'h0, CMD_PROGRAM);
    rarr(15'h500, 32'hffff);
    wreg(OFS_STAT, 32'h20);
    seq(15'h0, 16'h0, CMD_MASS);
    rreg(OFS_STAT, 32'h60, 32'h60);
    wreg(OFS_STAT, 32'h20);
    rreg(OFS_STAT, 32'h20, 32'h0);
    secure_en     <= 1'b1;
    nonsecure_src <= 1'b1;
    wr(aw(15'h500), 32'h0);
    wreg(OFS_CMD, 32'(CMD_PROGRAM));
    rreg(OFS_STAT, 32'h10, 32'h10);
    wreg(OFS_STAT, 32'h10);
    secure_en             <= 1'b0;
    nonsecure_src         <= 1'b0;
    background_debug_mode <= 1'b1;
    wreg(OFS_PROT, 32'h7);
    rreg(OFS_PROT, 32'h7, 32'h7);
    seq(15'h500, 16'h4321, CMD_PROGRAM);
    wait_bit(STAT_CC);
    rarr(15'h500, 32'h4321);
    $display("test protection done");
  endtask : t_prot
  // verdict and end of run
  task end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // watchdog against a hung wait
  initial begin
    #2_500_000;
    n_fail++;
    end_of_test;
  end
  // reset, then the scenarios
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_base;
    t_ops;
    t_stop;
    t_errs;
    t_prot;
    end_of_test;
  end
endmodule : flash_command_controller_test

// >>> rtl/fcc_engine.sv
`timescale 1ns/100ps
module fcc_engine
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // control
  input  wire logic              tick,
  input  wire logic              start,
  input  wire fcc_op_t           op,
  input  wire logic              abort,
  // status
  output logic                   busy,
  output logic                   done,
  output logic                   pass,
  // array read port
  input  wire logic [FCC_AW-1:0] rd_addr,
  output logic [15:0]            rd_data
);

  logic [15:0]       mem [0:(1<<FCC_AW)-1];
  fcc_eng_t          st_ff,   nxt_st;
  logic [7:0]        cmd_ff,  nxt_cmd;
  logic [FCC_AW-1:0] ptr_ff,  nxt_ptr;
  logic [FCC_AW-1:0] end_ff,  nxt_end;
  logic [15:0]       data_ff, nxt_data;
  logic [15:0]       cnt_ff,  nxt_cnt;
  logic              done_ff, nxt_done;
  logic              pass_ff, nxt_pass;
  logic              mem_we;
  logic [15:0]       mem_wd;

  assign busy    = (st_ff != ENG_IDLE);
  assign done    = done_ff;
  assign pass    = pass_ff;
  assign rd_data = mem[rd_addr];

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st   = st_ff;
    nxt_cmd  = cmd_ff;
    nxt_ptr  = ptr_ff;
    nxt_end  = end_ff;
    nxt_data = data_ff;
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    nxt_pass = pass_ff;
    mem_we   = 1'b0;
    mem_wd   = FCC_ERASED;
    case (st_ff)
      ENG_IDLE: begin
        if (start) begin
          nxt_st   = ENG_WAIT;
          nxt_cmd  = op.cmd;
          nxt_data = op.data;
          nxt_pass = 1'b0;
          nxt_ptr  = '0;
          nxt_end  = '1;
          nxt_cnt  = MASS_TICKS;
          if (op.cmd == CMD_PROGRAM) begin
            nxt_ptr = op.addr;
            nxt_cnt = PROG_TICKS;
          end else if (op.cmd == CMD_SECTOR) begin
            nxt_ptr = {op.addr[FCC_AW-1:FCC_SECT_W], {FCC_SECT_W{1'b0}}};
            nxt_end = {op.addr[FCC_AW-1:FCC_SECT_W], {FCC_SECT_W{1'b1}}};
            nxt_cnt = SECT_TICKS;
          end else if (op.cmd == CMD_VERIFY) begin
            nxt_cnt = VERIFY_TICKS;
          end
        end
      end
      ENG_WAIT: begin
        if (tick) begin
          nxt_cnt = cnt_ff - 16'h0001;
          if (cnt_ff == 16'h0001) begin
            nxt_st = ENG_SWEEP;
          end
        end
      end
      ENG_SWEEP: begin
        if (cmd_ff == CMD_PROGRAM) begin
          mem_we   = 1'b1;
          mem_wd   = data_ff;
          nxt_st   = ENG_IDLE;
          nxt_done = 1'b1;
        end else if (cmd_ff == CMD_VERIFY) begin
          if (mem[ptr_ff] != FCC_ERASED) begin
            nxt_pass = 1'b0;
            nxt_st   = ENG_IDLE;
            nxt_done = 1'b1;
          end else if (ptr_ff == end_ff) begin
            nxt_pass = 1'b1;
            nxt_st   = ENG_IDLE;
            nxt_done = 1'b1;
          end else begin
            nxt_ptr = ptr_ff + 1'b1;
          end
        end else begin
          mem_we = 1'b1;
          if (ptr_ff == end_ff) begin
            nxt_st   = ENG_IDLE;
            nxt_done = 1'b1;
          end else begin
            nxt_ptr = ptr_ff + 1'b1;
          end
        end
      end
      default: nxt_st = ENG_IDLE;
    endcase
    if (abort) begin
      nxt_st   = ENG_IDLE;
      nxt_done = 1'b0;
      mem_we   = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff   <= ENG_IDLE;
      cmd_ff  <= 8'h00;
      ptr_ff  <= '0;
      end_ff  <= '0;
      data_ff <= 16'h0000;
      cnt_ff  <= 16'h0000;
      done_ff <= 1'b0;
      pass_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      cmd_ff  <= nxt_cmd;
      ptr_ff  <= nxt_ptr;
      end_ff  <= nxt_end;
      data_ff <= nxt_data;
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
      pass_ff <= nxt_pass;
    end
  end

  // array cells, never reset
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[ptr_ff] <= mem_wd;
    end
  end

endmodule : fcc_engine

// >>> rtl/fcc_pkg.sv
package fcc_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int          FCC_AW        = 15;          // word index bits of the 16-bit array
  localparam int          FCC_SECT_W    = 9;           // word index bits inside one sector
  localparam int          FCC_ARR_SEL   = 20;          // haddr bit that selects the array
  localparam logic [15:0] FCC_ERASED    = 16'hffff;
  localparam logic [31:0] FCC_INVALID   = 32'h0000_0000;
  localparam logic [FCC_AW-1:0] FCC_LOW_PROT_END   = 15'h0400; // low region below this
  localparam logic [FCC_AW-1:0] FCC_HIGH_PROT_BASE = 15'h7c00; // high region from this

  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DIV  = 8'h00;  // timebase_divider_reg
  localparam logic [7:0] OFS_CFG  = 8'h04;  // irq enables
  localparam logic [7:0] OFS_PROT = 8'h08;  // protection_reg
  localparam logic [7:0] OFS_STAT = 8'h0c;  // flash_status_reg
  localparam logic [7:0] OFS_CMD  = 8'h10;  // command_code_reg

  localparam int STAT_CBE   = 7;
  localparam int STAT_CC    = 6;
  localparam int STAT_PV    = 5;
  localparam int STAT_ACC   = 4;
  localparam int STAT_BLANK = 2;
  localparam int DIV_LD     = 7;
  localparam int CFG_CBIE   = 7;
  localparam int CFG_COMPLETE_IRQ_ENABLE   = 6;
  localparam int PROT_OPEN  = 2;
  localparam int PROT_HDIS  = 1;
  localparam int PROT_LDIS  = 0;

  localparam logic [6:0] DIV_RST  = 7'h00;
  localparam logic [2:0] PROT_RST = 3'h7;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_VERIFY  = 8'h05;
  localparam logic [7:0] CMD_PROGRAM = 8'h20;
  localparam logic [7:0] CMD_SECTOR  = 8'h40;
  localparam logic [7:0] CMD_MASS    = 8'h41;

  // ----------------------------------------------------------------
  // operation durations in timebase ticks
  // ----------------------------------------------------------------
  localparam logic [15:0] PROG_TICKS   = 16'h0014;
  localparam logic [15:0] SECT_TICKS   = 16'h0040;
  localparam logic [15:0] MASS_TICKS   = 16'h0080;
  localparam logic [15:0] VERIFY_TICKS = 16'h0001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WORD = 2'b01,
    SEQ_CMD  = 2'b10
  } fcc_seq_t;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_WAIT  = 2'b01,
    ENG_SWEEP = 2'b10
  } fcc_eng_t;

  typedef struct packed {
    logic [7:0]        cmd;
    logic [FCC_AW-1:0] addr;
    logic [15:0]       data;
  } fcc_op_t;

  typedef struct packed {
    logic              wr;
    logic              arr;
    logic              regs;
    logic [7:0]        ofs;
    logic [FCC_AW-1:0] widx;
    logic [1:0]        lsb;
    logic [2:0]        size;
  } fcc_dphase_t;

endpackage : fcc_pkg

// >>> rtl/fcc_top.sv
// Summary of operation
// - only codes 05, 20, 40, 41 accepted
// - erase verify sets blank only if all erased
// - verify and mass erase ignore written address/data
// - program writes latched data at latched address
// - sector erase clears 1024-byte sector, low bits ignored
// - mass erase needs all protection bits open
// - protected program/erase target sets violation, aborts
// - complete flag only when no command buffered
// - bad array writes set access error
// - out-of-order sequence writes set access error
// - bad code or buffer-empty zero write errors
// - secure mode allows only mass erase from nonsecure or debug access
// - reads never error; busy array reads invalid
// - error flags lock out new launches
// - wait mode lets operations finish
// - stop aborts a running operation, sets complete and access error flags
// - debug mode: protection writable, secured mass only
// - launch clears complete; buffer-empty sets when free
// - divider write sets divider-loaded bit
// - interrupt from enabled empty or complete flag
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module fcc_top
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // system modes
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  input  wire logic        background_debug_mode,
  input  wire logic        secure_en,
  input  wire logic        nonsecure_src,
  // outputs to the system
  output logic             flash_irq,
  output logic             hv_enable
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  fcc_dphase_t       dp_ff,      nxt_dp;
  logic [31:0]       rdata_ff,   nxt_rdata;
  logic [6:0]        div_ff,     nxt_div;
  logic              divld_ff,   nxt_divld;
  logic [6:0]        tcnt_ff,    nxt_tcnt;
  logic [1:0]        cfg_ff,     nxt_cfg;
  logic [2:0]        prot_ff,    nxt_prot;
  logic              protwr_ff,  nxt_protwr;
  fcc_seq_t          seq_ff,     nxt_seq;
  fcc_op_t           word_ff,    nxt_word;
  fcc_op_t           pend_ff,    nxt_pend;
  logic              pendv_ff,   nxt_pendv;
  logic              cbe_ff,     nxt_cbe;
  logic              cc_ff,      nxt_cc;
  logic              acc_ff,     nxt_acc;
  logic              pv_ff,      nxt_pv;
  logic              blank_ff,   nxt_blank;
  logic              stopd_ff,   nxt_stopd;
  logic              tick;
  logic              ap_valid;
  logic              eng_start;
  logic              eng_abort;
  logic              eng_busy;
  logic              eng_done;
  logic              eng_pass;
  logic [15:0]       arr_rd;
  logic              stop_enter;
  logic              stop_exit;
  logic              acc_ev;
  logic              pv_ev;
  logic              launch;
  logic [7:0]        wcmd;

  // protection check of a target word for a given command
  function automatic logic prot_hit(input logic [7:0] cmd, input logic [FCC_AW-1:0] a,
                                    input logic [2:0] p);
    logic hit;
    hit = 1'b0;
    if (cmd == CMD_MASS) begin
      hit = !(&p);
    end else if (cmd != CMD_VERIFY) begin
      hit = !p[PROT_OPEN]
          || ((a < FCC_LOW_PROT_END) && !p[PROT_LDIS])
          || ((a >= FCC_HIGH_PROT_BASE) && !p[PROT_HDIS]);
    end
    return hit;
  endfunction : prot_hit

  // ----------------------------------------------------------------
  // bus side: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign ap_valid  = hsel && htrans[1] && hready;
  assign flash_irq = (cbe_ff && cfg_ff[1]) || (cc_ff && cfg_ff[0]);
  assign hv_enable = eng_busy && !stop_mode;
  assign tick      = divld_ff && (tcnt_ff == div_ff);
  assign stop_enter = stop_mode && !stopd_ff;
  assign stop_exit  = !stop_mode && stopd_ff;

  // address phase capture and read data
  always_comb begin
    nxt_dp    = '0;
    nxt_rdata = rdata_ff;
    if (ap_valid) begin
      nxt_dp.wr   = hwrite;
      nxt_dp.arr  = haddr[FCC_ARR_SEL];
      nxt_dp.regs = !haddr[FCC_ARR_SEL] && (haddr[FCC_ARR_SEL-1:8] == '0);
      nxt_dp.ofs  = haddr[7:0];
      nxt_dp.widx = haddr[FCC_AW+1:2];
      nxt_dp.lsb  = haddr[1:0];
      nxt_dp.size = hsize;
      if (!hwrite) begin
        nxt_rdata = 32'h0000_0000;
        if (haddr[FCC_ARR_SEL]) begin
          nxt_rdata = cc_ff ? {16'h0000, arr_rd} : FCC_INVALID;
        end else if (nxt_dp.regs && (haddr[7:0] == OFS_DIV)) begin
          nxt_rdata = {24'h000000, divld_ff, div_ff};
        end else if (nxt_dp.regs && (haddr[7:0] == OFS_CFG)) begin
          nxt_rdata = {24'h000000, cfg_ff, 6'h00};
        end else if (nxt_dp.regs && (haddr[7:0] == OFS_PROT)) begin
          nxt_rdata = {29'h00000000, prot_ff};
        end else if (nxt_dp.regs && (haddr[7:0] == OFS_STAT)) begin
          nxt_rdata = {24'h000000, cbe_ff, cc_ff, pv_ff, acc_ff, 1'b0, blank_ff, 2'b00};
        end else if (nxt_dp.regs && (haddr[7:0] == OFS_CMD)) begin
          nxt_rdata = {24'h000000, word_ff.cmd};
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dp_ff    <= '0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      dp_ff    <= nxt_dp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // command write sequence and status flags
  // ----------------------------------------------------------------
  always_comb begin
    nxt_div    = div_ff;
    nxt_divld  = divld_ff;
    nxt_tcnt   = tick ? 7'h00 : tcnt_ff + 7'h01;
    nxt_cfg    = cfg_ff;
    nxt_prot   = prot_ff;
    nxt_protwr = protwr_ff;
    nxt_seq    = seq_ff;
    nxt_word   = word_ff;
    nxt_pend   = pend_ff;
    nxt_pendv  = pendv_ff;
    nxt_cbe    = cbe_ff;
    nxt_cc     = cc_ff;
    nxt_acc    = acc_ff;
    nxt_pv     = pv_ff;
    nxt_blank  = blank_ff;
    nxt_stopd  = stop_mode;
    acc_ev     = 1'b0;
    pv_ev      = 1'b0;
    launch     = 1'b0;
    eng_start  = 1'b0;
    eng_abort  = 1'b0;
    wcmd       = hwdata[7:0];
    if (dp_ff.wr && dp_ff.arr) begin
      if (!divld_ff || (dp_ff.size != SIZE_WORD) || (dp_ff.lsb != 2'b00) || !cbe_ff) begin
        acc_ev = 1'b1;
      end else if (seq_ff != SEQ_IDLE) begin
        acc_ev = 1'b1;
      end else begin
        nxt_word.addr = dp_ff.widx;
        nxt_word.data = hwdata[15:0];
        nxt_seq       = SEQ_WORD;
      end
    end else if (dp_ff.wr && dp_ff.regs && (dp_ff.ofs == OFS_CMD)) begin
      if (seq_ff != SEQ_WORD) begin
        acc_ev = 1'b1;
      end else if ((wcmd != CMD_VERIFY) && (wcmd != CMD_PROGRAM)
                   && (wcmd != CMD_SECTOR) && (wcmd != CMD_MASS)) begin
        acc_ev = 1'b1;
      end else if (secure_en && (wcmd != CMD_MASS)
                   && (nonsecure_src || background_debug_mode)) begin
        acc_ev = 1'b1;
      end else if (prot_hit(wcmd, word_ff.addr, prot_ff)) begin
        pv_ev = 1'b1;
      end else begin
        nxt_word.cmd = wcmd;
        nxt_seq      = SEQ_CMD;
      end
    end else if (dp_ff.wr && dp_ff.regs && (dp_ff.ofs == OFS_STAT)) begin
      if (hwdata[STAT_ACC]) begin
        nxt_acc = 1'b0;
      end
      if (hwdata[STAT_PV]) begin
        nxt_pv = 1'b0;
      end
      if (seq_ff == SEQ_WORD) begin
        acc_ev = 1'b1;
      end else if ((seq_ff == SEQ_CMD) && !hwdata[STAT_CBE]) begin
        acc_ev = 1'b1;
      end else if (seq_ff == SEQ_CMD) begin
        nxt_seq = SEQ_IDLE;
        launch  = !(acc_ff || pv_ff);
      end
    end else if (dp_ff.wr && dp_ff.regs) begin
      if (seq_ff != SEQ_IDLE) begin
        acc_ev = 1'b1;
      end else if (dp_ff.ofs == OFS_DIV) begin
        nxt_div   = hwdata[6:0];
        nxt_divld = 1'b1;
        nxt_tcnt  = 7'h00;
      end else if (dp_ff.ofs == OFS_CFG) begin
        nxt_cfg = hwdata[CFG_CBIE:CFG_COMPLETE_IRQ_ENABLE];
      end else if ((dp_ff.ofs == OFS_PROT) && (background_debug_mode || !protwr_ff)) begin
        nxt_prot   = hwdata[2:0];
        nxt_protwr = 1'b1;
      end
    end
    // launch into the second buffer stage
    if (launch) begin
      nxt_pend  = word_ff;
      nxt_pendv = 1'b1;
      nxt_cbe   = 1'b0;
      nxt_cc    = 1'b0;
      nxt_blank = 1'b0;
    end
    // move buffered command into the engine once it is free
    if (pendv_ff && !eng_busy && !stop_mode) begin
      eng_start = 1'b1;
      nxt_pendv = 1'b0;
      nxt_cbe   = 1'b1;
    end
    // completion: flag only with nothing left buffered
    if (eng_done) begin
      // pass is cleared at each start, so only a passing verify sets blank
      nxt_blank = eng_pass;
      if (!pendv_ff && !launch) begin
        nxt_cc = 1'b1;
      end
    end
    // stop mode aborts the running and buffered work
    if (stop_enter && !cc_ff) begin
      eng_abort = 1'b1;
      eng_start = 1'b0;
      nxt_pendv = 1'b0;
      nxt_cc    = 1'b1;
      acc_ev    = 1'b1;
    end
    if (stop_exit) begin
      nxt_cbe   = 1'b1;
      nxt_pendv = 1'b0;
    end
    // error events abort the sequence; a set wins over a clear
    if (acc_ev || pv_ev) begin
      nxt_seq = SEQ_IDLE;
    end
    if (acc_ev) begin
      nxt_acc = 1'b1;
    end
    if (pv_ev) begin
      nxt_pv = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff    <= DIV_RST;
      divld_ff  <= 1'b0;
      tcnt_ff   <= 7'h00;
      cfg_ff    <= 2'b00;
      prot_ff   <= PROT_RST;
      protwr_ff <= 1'b0;
      seq_ff    <= SEQ_IDLE;
      word_ff   <= '0;
      pend_ff   <= '0;
      pendv_ff  <= 1'b0;
      cbe_ff    <= 1'b1;
      cc_ff     <= 1'b1;
      acc_ff    <= 1'b0;
      pv_ff     <= 1'b0;
      blank_ff  <= 1'b0;
      stopd_ff  <= 1'b0;
    end else begin
      div_ff    <= nxt_div;
      divld_ff  <= nxt_divld;
      tcnt_ff   <= nxt_tcnt;
      cfg_ff    <= nxt_cfg;
      prot_ff   <= nxt_prot;
      protwr_ff <= nxt_protwr;
      seq_ff    <= nxt_seq;
      word_ff   <= nxt_word;
      pend_ff   <= nxt_pend;
      pendv_ff  <= nxt_pendv;
      cbe_ff    <= nxt_cbe;
      cc_ff     <= nxt_cc;
      acc_ff    <= nxt_acc;
      pv_ff     <= nxt_pv;
      blank_ff  <= nxt_blank;
      stopd_ff  <= nxt_stopd;
    end
  end

  // ----------------------------------------------------------------
  // array and algorithm engine
  // ----------------------------------------------------------------
  fcc_engine u_engine (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (tick),
    .start    (eng_start),
    .op       (pend_ff),
    .abort    (eng_abort),
    .busy     (eng_busy),
    .done     (eng_done),
    .pass     (eng_pass),
    .rd_addr  (haddr[FCC_AW+1:2]),
    .rd_data  (arr_rd)
  );

endmodule : fcc_top
